// >>> common/mixer_tone_pkg.sv
// constants and register layouts for the mixer gain and tone burst block
// assumes a 200 MHz aclk and a one-cycle word clock tick from the codec
package mixer_tone_pkg;

  // printed offsets are indices; the byte address is four times the index
  localparam int REG_IDX_MIXER  = 3;
  localparam int REG_IDX_AUDIO2 = 4;
  localparam int REG_IDX_IRQ_ST = 8;
  localparam int REG_IDX_IRQ_MK = 9;
  localparam logic [7:0] ADDR_MIXER  = 8'(REG_IDX_MIXER * 4);
  localparam logic [7:0] ADDR_AUDIO2 = 8'(REG_IDX_AUDIO2 * 4);
  localparam logic [7:0] ADDR_IRQ_ST = 8'(REG_IDX_IRQ_ST * 4);
  localparam logic [7:0] ADDR_IRQ_MK = 8'(REG_IDX_IRQ_MK * 4);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       sidetone_mute;
    logic [6:0] sidetone_gain;
    logic [2:0] input_source_select;
    logic       selected_input_to_adc;
    logic       cellular_input_to_adc;
    logic [1:0] reserved;
    logic       sidetone_gain_settled_flag;
  } mixer_reg_s;

  typedef struct packed {
    logic       tone_burst_enable;
    logic [2:0] tone_burst_amplitude;
    logic       input_gain_step_rate;
    logic [2:0] tone_burst_frequency;
    logic [3:0] tone_burst_length;
    logic       left_dac_gain_settled_flag;
    logic       right_dac_gain_settled_flag;
    logic       dac_gain_step_rate;
    logic       input_gain_settled_flag;
  } audio2_reg_s;

  localparam logic [15:0] MIXER_RESET  = 16'hC500;
  localparam logic [15:0] AUDIO2_RESET = 16'h4410;

  // sidetone gain coding in half-dB units
  localparam logic [6:0] ST_GAIN_ZERO_CODE   = 7'h45;
  localparam logic [6:0] ST_GAIN_SAT_CODE    = 7'h5D;
  localparam logic [7:0] ST_GAIN_MAX_HALF_DB = 8'h18;

  // interrupt status bit positions
  localparam int IRQ_TONE_DONE = 0;
  localparam int IRQ_ST_SETTLE = 1;
  localparam int IRQ_DL_SETTLE = 2;
  localparam int IRQ_DR_SETTLE = 3;
  localparam int IRQ_IN_SETTLE = 4;
  localparam int IRQ_W         = 5;

  // tone burst timing: lowest frequency 62.5 Hz, in milli-hertz
  localparam longint CLK_FREQ_HZ       = 200_000_000;
  localparam longint TONE_BASE_FREQ_MHZ = 62_500;
  localparam int TONE_HALF_BASE_CYCLES =
    int'(CLK_FREQ_HZ * 1000 / (2 * TONE_BASE_FREQ_MHZ));

endpackage

// >>> rtl/mixer_gain_and_tone_burst_control.sv
// mixer gain, input routing and tone burst control registers
// assumes an AXI4-Lite master on aclk and a synchronous one-cycle wclk_tick
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module gain_stepper #(
  parameter int W = 7
) (
  input  wire logic         aclk,    // clock
  input  wire logic         aresetn, // sync reset, active low
  input  wire logic         step,    // one-cycle step strobe
  input  wire logic         hold,    // freeze applied gain
  input  wire logic [W-1:0] target,  // programmed gain code
  output logic      [W-1:0] applied, // gain code now applied
  output logic              settled  // applied equals target
);
  logic [W-1:0] applied_reg;

  // one code (0.5 dB) per step toward the target
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      applied_reg <= '0;
    end else if (step && !hold && applied_reg != target) begin
      if (applied_reg < target) begin
        applied_reg <= W'(applied_reg + 1'b1);
      end else begin
        applied_reg <= W'(applied_reg - 1'b1);
      end
    end
  end

  assign applied = applied_reg;
  assign settled = (applied_reg == target);
endmodule

module mixer_gain_and_tone_burst_control
  import mixer_tone_pkg::*;
#(
  parameter int TONE_HALF_BASE = TONE_HALF_BASE_CYCLES
) (
  input  wire logic        aclk,                  // 200 MHz clock
  input  wire logic        aresetn,               // sync reset, low
  input  wire logic [7:0]  s_axi_awaddr,          // write address
  input  wire logic        s_axi_awvalid,         // write address valid
  output logic             s_axi_awready,         // write address ready
  input  wire logic [31:0] s_axi_wdata,           // write data
  input  wire logic [3:0]  s_axi_wstrb,           // byte strobes
  input  wire logic        s_axi_wvalid,          // write data valid
  output logic             s_axi_wready,          // write data ready
  output logic [1:0]       s_axi_bresp,           // write response
  output logic             s_axi_bvalid,          // response valid
  input  wire logic        s_axi_bready,          // response ready
  input  wire logic [7:0]  s_axi_araddr,          // read address
  input  wire logic        s_axi_arvalid,         // read address valid
  output logic             s_axi_arready,         // read address ready
  output logic [31:0]      s_axi_rdata,           // read data
  output logic [1:0]       s_axi_rresp,           // read response
  output logic             s_axi_rvalid,          // read data valid
  input  wire logic        s_axi_rready,          // read data ready
  input  wire logic        wclk_tick,             // word clock pulse
  input  wire logic        headset_auto_gain_enable, // agc on
  input  wire logic        agc_noise_below,       // power under threshold
  input  wire logic        agc_saturated,         // agc at its limit
  input  wire logic [6:0]  input_gain_target,     // programmed input pga
  input  wire logic [6:0]  dac_left_target,       // programmed left gain
  input  wire logic [6:0]  dac_right_target,      // programmed right gain
  output logic             sidetone_muted,        // sidetone path muted
  output logic [7:0]       sidetone_gain_half_db, // signed, 0.5 dB units
  output logic [3:0]       adc_input_connect,     // hed, hnd, auxiliary_input_one, auxiliary_input_two
  output logic             adc_differential,      // differential pair
  output logic             cellular_to_adc,       // cellular to adc
  output logic             input_pga_by_agc,      // pga follows agc
  output logic [6:0]       input_gain_applied,    // stepped input gain
  output logic [6:0]       dac_left_applied,      // stepped left gain
  output logic [6:0]       dac_right_applied,     // stepped right gain
  output logic             tone_out,              // tone square wave
  output logic [2:0]       tone_level,            // tone amplitude code
  output logic             irq                    // level interrupt
);
  localparam int TW = $clog2(TONE_HALF_BASE + 1);

  // the fastest code shifts the base seven times and still needs two cycles
  if (TONE_HALF_BASE < 256) begin : g_base_check
    $error("TONE_HALF_BASE too small for the frequency shift");
  end

  mixer_reg_s   mixer_reg;
  audio2_reg_s  audio2_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] flags_prev_reg;
  logic [IRQ_W-1:0] events;

  logic        aw_hold_reg;
  logic [7:0]  awaddr_reg;
  logic        w_hold_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        do_write;
  logic [15:0] wr_mask;

  logic        tick_phase_reg;
  logic        step_fast;
  logic        step_slow;
  logic        st_settled;
  logic        dl_settled;
  logic        dr_settled;
  logic        in_settled;
  logic [6:0]  st_applied;

  logic [TW-1:0] tone_cnt_reg;
  logic [6:0]    tone_halves_reg;
  logic          tone_out_reg;
  logic [TW-1:0] tone_half_lim;
  logic [6:0]    tone_halves_total;
  logic          tone_wrap;
  logic          tone_done;

  mixer_reg_s  mixer_view;
  audio2_reg_s audio2_view;
  logic [15:0] wr_mixer;
  logic [15:0] wr_audio2;

  // ---------------- bus slave, write channel ----------------
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign do_write      = aw_hold_reg && w_hold_reg;
  assign wr_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      case (awaddr_reg)
        ADDR_MIXER, ADDR_AUDIO2, ADDR_IRQ_ST, ADDR_IRQ_MK: begin
          bresp_reg <= RESP_OKAY;
        end
        default: begin
          bresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // merged write values under the byte strobes
  assign wr_mixer  = (wdata_reg[15:0] & wr_mask) | (mixer_reg & ~wr_mask);
  assign wr_audio2 = (wdata_reg[15:0] & wr_mask) | (audio2_reg & ~wr_mask);

  // ---------------- control registers ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mixer_reg <= MIXER_RESET;
    end else if (do_write && awaddr_reg == ADDR_MIXER) begin
      mixer_reg <= wr_mixer;
      // flag and reserved bits are not storage
      mixer_reg.reserved                   <= 2'h0;
      mixer_reg.sidetone_gain_settled_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      audio2_reg <= AUDIO2_RESET;
    end else begin
      if (do_write && awaddr_reg == ADDR_AUDIO2) begin
        audio2_reg <= wr_audio2;
        audio2_reg.left_dac_gain_settled_flag  <= 1'b0;
        audio2_reg.right_dac_gain_settled_flag <= 1'b0;
        audio2_reg.input_gain_settled_flag     <= 1'b0;
        if (headset_auto_gain_enable) begin
          // step rate is a status bit while agc runs
          audio2_reg.input_gain_step_rate <=
            audio2_reg.input_gain_step_rate;
        end
      end else if (tone_done) begin
        // a software restart in the same cycle wins
        audio2_reg.tone_burst_enable <= 1'b0;
      end
    end
  end

  // ---------------- soft stepping ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_phase_reg <= 1'b0;
    end else if (wclk_tick) begin
      tick_phase_reg <= !tick_phase_reg;
    end
  end

  assign step_fast = wclk_tick;
  assign step_slow = wclk_tick && tick_phase_reg;

  gain_stepper #(.W(7)) u_sidetone (
    .aclk    (aclk),
    .aresetn (aresetn),
    .step    (step_fast),
    .hold    (1'b0),
    .target  (mixer_reg.sidetone_gain),
    .applied (st_applied),
    .settled (st_settled)
  );

  gain_stepper #(.W(7)) u_input (
    .aclk    (aclk),
    .aresetn (aresetn),
    .step    (audio2_reg.input_gain_step_rate ? step_slow
                                              : step_fast),
    .hold    (headset_auto_gain_enable),
    .target  (input_gain_target),
    .applied (input_gain_applied),
    .settled (in_settled)
  );

  gain_stepper #(.W(7)) u_dac_left (
    .aclk    (aclk),
    .aresetn (aresetn),
    .step    (audio2_reg.dac_gain_step_rate ? step_slow : step_fast),
    .hold    (1'b0),
    .target  (dac_left_target),
    .applied (dac_left_applied),
    .settled (dl_settled)
  );

  gain_stepper #(.W(7)) u_dac_right (
    .aclk    (aclk),
    .aresetn (aresetn),
    .step    (audio2_reg.dac_gain_step_rate ? step_slow : step_fast),
    .hold    (1'b0),
    .target  (dac_right_target),
    .applied (dac_right_applied),
    .settled (dr_settled)
  );

  // ---------------- sidetone and routing outputs ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sidetone_muted        <= 1'b1;
      sidetone_gain_half_db <= 8'h00;
    end else begin
      sidetone_muted <= mixer_reg.sidetone_mute;
      if (st_applied >= ST_GAIN_SAT_CODE) begin
        sidetone_gain_half_db <= ST_GAIN_MAX_HALF_DB;
      end else begin
        sidetone_gain_half_db <=
          8'({1'b0, st_applied} - {1'b0, ST_GAIN_ZERO_CODE});
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_input_connect <= 4'h0;
      adc_differential  <= 1'b0;
      cellular_to_adc   <= 1'b0;
      input_pga_by_agc  <= 1'b0;
    end else begin
      adc_differential <= mixer_reg.input_source_select[2];
      if (!mixer_reg.selected_input_to_adc) begin
        adc_input_connect <= 4'h0;
      end else if (mixer_reg.input_source_select[2]) begin
        // bit order hed, hnd, auxiliary_input_one, auxiliary_input_two from lsb
        adc_input_connect <= {mixer_reg.input_source_select[0],
                              !mixer_reg.input_source_select[0],
                              mixer_reg.input_source_select[1],
                              !mixer_reg.input_source_select[1]};
      end else begin
        adc_input_connect <=
          4'(4'h1 << mixer_reg.input_source_select[1:0]);
      end
      cellular_to_adc  <= mixer_reg.cellular_input_to_adc;
      input_pga_by_agc <= headset_auto_gain_enable;
    end
  end

  // ---------------- tone burst ----------------
  assign tone_half_lim =
    TW'(TONE_HALF_BASE >> audio2_reg.tone_burst_frequency);
  // two periods per length step, counted in half periods
  assign tone_halves_total =
    7'({audio2_reg.tone_burst_length, 2'b00} + 7'h04);
  assign tone_wrap = audio2_reg.tone_burst_enable &&
                     tone_cnt_reg == TW'(tone_half_lim - 1'b1);
  assign tone_done = tone_wrap &&
                     tone_halves_reg == 7'(tone_halves_total - 1'b1);

  always_ff @(posedge aclk) begin
    if (!aresetn || !audio2_reg.tone_burst_enable) begin
      tone_cnt_reg    <= '0;
      tone_halves_reg <= 7'h00;
      tone_out_reg    <= 1'b0;
    end else if (tone_wrap) begin
      tone_cnt_reg    <= '0;
      tone_halves_reg <= 7'(tone_halves_reg + 1'b1);
      tone_out_reg    <= !tone_out_reg && !tone_done;
    end else begin
      tone_cnt_reg <= TW'(tone_cnt_reg + 1'b1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tone_level <= 3'h4;
    end else begin
      tone_level <= audio2_reg.tone_burst_amplitude;
    end
  end

  assign tone_out = tone_out_reg;

  // ---------------- interrupts ----------------
  // events are rising settled flags and the end of a burst
  assign events[IRQ_TONE_DONE] = tone_done;
  assign events[IRQ_ST_SETTLE] = st_settled && !flags_prev_reg[1];
  assign events[IRQ_DL_SETTLE] = dl_settled && !flags_prev_reg[2];
  assign events[IRQ_DR_SETTLE] = dr_settled && !flags_prev_reg[3];
  assign events[IRQ_IN_SETTLE] = in_settled && !flags_prev_reg[4];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_prev_reg <= '0;
    end else begin
      flags_prev_reg <= {in_settled, dr_settled, dl_settled,
                         st_settled, 1'b0};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= '0;
    end else if (do_write && awaddr_reg == ADDR_IRQ_ST &&
                 wstrb_reg[0]) begin
      // a new event beats the one-to-clear
      irq_status_reg <= (irq_status_reg & ~wdata_reg[IRQ_W-1:0]) | events;
    end else begin
      irq_status_reg <= irq_status_reg | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_reg <= '0;
    end else if (do_write && awaddr_reg == ADDR_IRQ_MK && wstrb_reg[0]) begin
      irq_mask_reg <= wdata_reg[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // ---------------- bus slave, read channel ----------------
  always_comb begin
    mixer_view = mixer_reg;
    mixer_view.reserved = 2'h0;
    mixer_view.sidetone_gain_settled_flag = st_settled;
    audio2_view = audio2_reg;
    audio2_view.left_dac_gain_settled_flag  = dl_settled;
    audio2_view.right_dac_gain_settled_flag = dr_settled;
    if (headset_auto_gain_enable) begin
      audio2_view.input_gain_step_rate    = agc_noise_below;
      audio2_view.input_gain_settled_flag = agc_saturated;
    end else begin
      audio2_view.input_gain_settled_flag = in_settled;
    end
  end

  assign s_axi_arready = !rvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_MIXER:  rdata_reg <= {16'h0000, mixer_view};
        ADDR_AUDIO2: rdata_reg <= {16'h0000, audio2_view};
        ADDR_IRQ_ST: rdata_reg <= {27'h000_0000, irq_status_reg};
        ADDR_IRQ_MK: rdata_reg <= {27'h000_0000, irq_mask_reg};
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;
endmodule

`default_nettype wire

// >>> test/word_clock_source.sv
// word clock model: the codec frame timing seen by the control block
// assumes the block samples one-cycle ticks on aclk
`timescale 1ns/1ps
`default_nettype none
module word_clock_source #(
  parameter int PERIOD = 4
) (
  input  wire logic aclk,      // clock
  input  wire logic aresetn,   // sync reset
  output logic      wclk_tick  // one pulse per word
);
  int cnt;
  // short period keeps soft-step ramps inside a brief run
  always_ff @(posedge aclk) begin
    if (!aresetn || cnt == PERIOD - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  always_ff @(posedge aclk) begin
    wclk_tick <= aresetn && cnt == PERIOD - 1;
  end
endmodule
`default_nettype wire

// >>> test/mixer_gain_and_tone_burst_control_props.sv
// port checker for the mixer gain and tone burst block
// assumes a single aclk domain, bound to the block top
`timescale 1ns/1ps
`default_nettype none
module mixer_tone_checker (
  input wire logic       aclk,                     // clock
  input wire logic       aresetn,                  // sync reset
  input wire logic       s_axi_awvalid,            // aw valid
  input wire logic       s_axi_awready,            // aw ready
  input wire logic       s_axi_wvalid,             // w valid
  input wire logic       s_axi_wready,             // w ready
  input wire logic       s_axi_bvalid,             // b valid
  input wire logic       s_axi_arvalid,            // ar valid
  input wire logic       s_axi_arready,            // ar ready
  input wire logic       s_axi_rvalid,             // r valid
  input wire logic       s_axi_rready,             // r ready
  input wire logic [31:0] s_axi_rdata,             // read data
  input wire logic       headset_auto_gain_enable, // agc on
  input wire logic       input_pga_by_agc,         // agc owns pga
  input wire logic [6:0] input_gain_applied,       // input gain
  input wire logic [6:0] dac_right_applied,        // right gain
  input wire logic [7:0] sidetone_gain_half_db     // sidetone gain
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid; // both halves are held a cycle before the answer
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("no bvalid");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("no rvalid");
  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
  property p_gain_cap;
    $signed(sidetone_gain_half_db) <= 8'sd24;
  endproperty
  a_gain_cap: assert property (p_gain_cap) else $error("gain cap");
  property p_agc_follow;
    $past(aresetn) |-> input_pga_by_agc == $past(headset_auto_gain_enable);
  endproperty
  a_agc_follow: assert property (p_agc_follow) else $error("agc");
  property p_agc_freeze;
    $past(aresetn) && input_pga_by_agc && $past(input_pga_by_agc)
      |-> $stable(input_gain_applied);
  endproperty
  a_agc_freeze: assert property (p_agc_freeze) else $error("pga");
  // one code per step, either way, modulo the 7-bit code
  property p_input_step;
    $past(aresetn) && $changed(input_gain_applied) |->
      7'(input_gain_applied - $past(input_gain_applied)) inside {7'h01, 7'h7F};
  endproperty
  a_input_step: assert property (p_input_step) else $error("step");
  property p_dac_step;
    $past(aresetn) && $changed(dac_right_applied) |->
      7'(dac_right_applied - $past(dac_right_applied)) inside {7'h01, 7'h7F};
  endproperty
  a_dac_step: assert property (p_dac_step) else $error("dac step");
endmodule
bind mixer_gain_and_tone_burst_control mixer_tone_checker mixer_tone_checker_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .headset_auto_gain_enable,
  .input_pga_by_agc, .input_gain_applied, .dac_right_applied,
  .sidetone_gain_half_db);
`default_nettype wire

// >>> test/mixer_gain_and_tone_burst_control_tb.sv
// self-checking bench for the mixer gain and tone burst block
// assumes the word clock model and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module mixer_gain_and_tone_burst_control_tb;
  import mixer_tone_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, sidetone_gain_half_db;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, adc_input_connect, e;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [6:0]  input_gain_target, dac_left_target, dac_right_target, g;
  logic [6:0]  input_gain_applied, dac_left_applied, dac_right_applied;
  logic [2:0]  tone_level;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, wclk_tick, headset_auto_gain_enable;
  logic agc_noise_below, agc_saturated, sidetone_muted, adc_differential;
  logic cellular_to_adc, input_pga_by_agc, tone_out, irq;
  logic [33:0] exp_q[$];
  int error_cnt = 0, total_checks = 0, tone_rises = 0, seed = 24853;
  int tone_high = 0;
  // adc routing per source code: hed, hnd, auxiliary_input_one, auxiliary_input_two from lsb
  logic [3:0] route_tbl [8] = '{4'h1, 4'h2, 4'h4, 4'h8,
                                4'h5, 4'h9, 4'h6, 4'hA};

  word_clock_source #(.PERIOD(4)) word_clock_source_i (
    .aclk, .aresetn, .wclk_tick);
  mixer_gain_and_tone_burst_control #(.TONE_HALF_BASE(256))
    mixer_gain_and_tone_burst_control_i (.*);

  always #2.5 aclk = ~aclk;
  always @(posedge tone_out) tone_rises++;
  always @(posedge aclk) tone_high += tone_out;

  task automatic chk(input string n, input logic [33:0] x, s);
    total_checks++;
    if (x !== s) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask

  // results are paired with the oldest note as they appear on the bus
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      chk("bresp", exp_q.pop_front(), {32'h0000_0000, s_axi_bresp});
    end
    if (s_axi_rvalid && s_axi_rready) begin
      chk("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    end
  end

  // handshakes are judged at the falling edge, acted on after the rise
  task automatic bus(input logic rd, input logic [7:0] a,
                     input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    logic ta, tw, tr, td;
    exp_q.push_back(rd ? {r, d} : {32'h0000_0000, r});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= !rd;
    s_axi_wvalid <= !rd;
    s_axi_bready <= !rd;
    s_axi_arvalid <= rd;
    s_axi_rready <= rd;
    forever begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tr = s_axi_arready;
      td = s_axi_bvalid || s_axi_rvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      if (td) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #50000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    {headset_auto_gain_enable, agc_noise_below, agc_saturated} = '0;
    input_gain_target = 7'h03;
    dac_left_target = 7'h05;
    dac_right_target = 7'h05;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    bus(1'b1, ADDR_MIXER, 32'h0000_C500);
    bus(1'b1, ADDR_AUDIO2, 32'h0000_4410);
    bus(1'b1, 8'h14, 32'h0000_0000, RESP_SLVERR);
    bus(1'b0, 8'h14, 32'hFFFF_FFFF, RESP_SLVERR);
    chk("muted", 1, sidetone_muted);
    chk("level", 4, tone_level);
    for (int i = 0; i < 16; i++) begin
      bus(1'b0, ADDR_MIXER, {16'hFFFF, 1'b1, 7'h45, i[2:0], i[3], 4'hF});
      e = route_tbl[i[2:0]];
      // outputs launched at the closing edge are read half a cycle later
      @(negedge aclk);
      chk("connect", i[3] ? e : 4'h0, adc_input_connect);
      chk("diff", i[2], adc_differential);
    end
    repeat (600) @(posedge aclk);
    g = 7'(77 + ($random(seed) & 'h3F));
    bus(1'b0, ADDR_MIXER, {16'h0000, 1'b0, g, 8'h0F});
    bus(1'b1, ADDR_MIXER, {16'h0000, 1'b0, g, 8'h08});
    chk("cell", 1, cellular_to_adc);
    chk("muted", 0, sidetone_muted);
    repeat (600) @(posedge aclk);
    bus(1'b1, ADDR_MIXER, {16'h0000, 1'b0, g, 8'h09});
    chk("gain", (g >= 7'h5D) ? 8'h18 : 8'(g) - 8'h45,
        sidetone_gain_half_db);
    bus(1'b0, ADDR_IRQ_ST, 32'h0000_001F);
    bus(1'b0, ADDR_IRQ_MK, 32'h0000_0001);
    chk("irq", 0, irq);
    tone_rises = 0;
    tone_high = 0;
    bus(1'b0, ADDR_AUDIO2, 32'h0000_D70D);
    @(negedge aclk);
    chk("level", 5, tone_level);
    repeat (60) @(posedge aclk);
    chk("rises", 2, tone_rises);
    chk("high", 4, tone_high);
    chk("irq", 1, irq);
    bus(1'b1, ADDR_AUDIO2, 32'h0000_570D);
    bus(1'b1, ADDR_IRQ_ST, 32'h0000_0001);
    bus(1'b0, ADDR_IRQ_ST, 32'h0000_0001);
    chk("irq", 0, irq);
    bus(1'b0, ADDR_AUDIO2, 32'h0000_4C10);
    input_gain_target <= 7'h28;
    bus(1'b1, ADDR_AUDIO2, 32'h0000_4C1C);
    repeat (200) @(posedge aclk);
    bus(1'b1, ADDR_AUDIO2, 32'h0000_4C1C);
    repeat (200) @(posedge aclk);
    bus(1'b1, ADDR_AUDIO2, 32'h0000_4C1D);
    bus(1'b0, ADDR_AUDIO2, 32'h0000_4410);
    {headset_auto_gain_enable, agc_noise_below, agc_saturated} <= 3'b111;
    input_gain_target <= 7'h0A;
    dac_right_target <= 7'h64;
    repeat (50) @(posedge aclk);
    chk("agc", 1, input_pga_by_agc);
    bus(1'b1, ADDR_AUDIO2, 32'h0000_4C19);
    chk("frozen", 7'h28, input_gain_applied);
    chk("dleft", 7'h05, dac_left_applied);
    bus(1'b0, ADDR_AUDIO2, 32'h0000_4C10);
    {headset_auto_gain_enable, agc_noise_below} <= 2'b00;
    repeat (3) @(posedge aclk);
    bus(1'b1, ADDR_AUDIO2, 32'h0000_4418);
    end_of_test();
  end
endmodule
`default_nettype wire
